// [pcs_port.sv]
/*
  Four-pin multi-purpose port with per-pin chip-select strobes and a
  classic Wishbone register slave.
  Assumes the external bus address and read/write pulses come from core
  logic on clk_i, while the pins themselves are asynchronous inputs.
*/
// The Wishbone slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module pcs_port
  import pcs_pkg::*;
#(
  parameter int PINS = 4   // Number of port pins.
)(
  input  wire logic                   clk_i,          // Core clock, 25 MHz.
  input  wire logic                   rst_i,          // Synchronous reset.
  // Wishbone slave.
  input  wire logic [7:0]             wb_adr_i,       // Byte address.
  input  wire logic [31:0]            wb_dat_i,       // Write data.
  input  wire logic [3:0]             wb_sel_i,       // Byte lanes.
  input  wire logic                   wb_we_i,        // Write enable.
  input  wire logic                   wb_cyc_i,       // Cycle.
  input  wire logic                   wb_stb_i,       // Strobe.
  output logic      [31:0]            wb_dat_o,       // Read data.
  output logic                        wb_ack_o,       // Acknowledge.
  // External bus cycle from the core.
  input  wire pcs_pkg::pcs_xbus_s     xbus_i,         // Address, rd, wr.
  // Interrupt enables from the interrupt controller.
  input  wire logic                   int_two_en_i,   // Enable for two.
  input  wire logic                   int_three_en_i, // Enable for three.
  // Port pins.
  input  wire logic [PINS-1:0]        pin_i,          // Pin levels.
  output logic      [PINS-1:0]        pin_o,          // Pin drive value.
  output logic      [PINS-1:0]        pin_oe_o,       // High while driving.
  // Interrupt pin levels toward the interrupt controller.
  output logic                        external_interrupt_two_o,
  output logic                        external_interrupt_three_o
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [PINS-1:0] port_four_data_q;          // Port data latch.
  logic [PINS-1:0] port_four_data_d;
  logic [7:0]      pin_mode_control_a_q;      // Pins 0 and 1.
  logic [7:0]      pin_mode_control_b_q;      // Pins 2 and 3.
  logic [PINS-1:0] strobe_invert_q;           // Bit 0 is pin0_strobe_invert.
  logic [7:0]      strobe_address_high_byte_q [PINS];
  logic [7:0]      strobe_address_low_byte_q  [PINS];
  logic            ack_q;                     // Wishbone acknowledge.
  logic [31:0]     rdata_q;                   // Registered read data.

  // ---------------------------------------------------------------
  // Pin input filter
  // ---------------------------------------------------------------
  // Three flops; the filtered level only moves when the second and third
  // stages agree, which rejects a single-cycle glitch on the pin.
  logic [PINS-1:0] sync1_q;
  logic [PINS-1:0] sync2_q;
  logic [PINS-1:0] sync3_q;
  logic [PINS-1:0] pin_level_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q     <= {PINS{1'b1}};
      sync2_q     <= {PINS{1'b1}};
      sync3_q     <= {PINS{1'b1}};
      pin_level_q <= {PINS{1'b1}};
    end else begin
      sync1_q     <= pin_i;
      sync2_q     <= sync1_q;
      sync3_q     <= sync2_q;
      pin_level_q <= (sync2_q & sync3_q) | (pin_level_q & (sync2_q ^ sync3_q));
    end
  end

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // Returns the pin index whose per-pin register sits at the address,
  // relative to the base of that register bank.
  function automatic logic [1:0] pin_index(input logic [7:0] adr,
                                           input logic [7:0] base);
    logic [7:0] rel;
    rel       = adr - base;
    pin_index = rel[3:2];
  endfunction

  // Tests that an address falls inside a per-pin bank.
  // The pin count is compared at eight bits, because a two-bit pin count
  // would wrap four pins to zero and close the whole bank.
  function automatic logic in_bank(input logic [7:0] adr,
                                   input logic [7:0] base);
    logic [7:0] rel;
    rel     = adr - base;
    in_bank = (adr >= base) && (rel[7:4] == 4'h0) && (rel[1:0] == 2'b00) &&
              ({6'h00, rel[3:2]} < 8'(PINS));
  endfunction

  wire       bus_req;       // Request waiting for an acknowledge.
  wire       wr_lo;         // Write with the low byte lane enabled.
  wire       hit_data;
  wire       hit_mode_a;
  wire       hit_mode_b;
  wire       hit_pins;
  wire       hit_inv;
  wire       hit_hi;
  wire       hit_lo;
  wire [1:0] idx_hi;
  wire [1:0] idx_lo;
  wire [7:0] wbyte;

  assign bus_req    = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_lo      = bus_req && wb_we_i && wb_sel_i[0];
  assign wbyte      = wb_dat_i[7:0];
  assign hit_data   = (wb_adr_i == PCS_OFF_DATA);
  assign hit_mode_a = (wb_adr_i == PCS_OFF_MODE_A);
  assign hit_mode_b = (wb_adr_i == PCS_OFF_MODE_B);
  assign hit_pins   = (wb_adr_i == PCS_OFF_PINS);
  assign hit_inv    = (wb_adr_i == PCS_OFF_INVERT);
  assign hit_hi     = in_bank(wb_adr_i, PCS_OFF_ADR_HI);
  assign hit_lo     = in_bank(wb_adr_i, PCS_OFF_ADR_LO);
  assign idx_hi     = pin_index(wb_adr_i, PCS_OFF_ADR_HI);
  assign idx_lo     = pin_index(wb_adr_i, PCS_OFF_ADR_LO);

  // ---------------------------------------------------------------
  // Per-pin configuration
  // ---------------------------------------------------------------
  // The two mode registers are joined so pin n owns nibble n.
  wire [15:0]      mode_bits;
  pcs_pin_cfg_s    cfg    [PINS];
  logic [PINS-1:0] is_gpio;
  logic [PINS-1:0] strobe_level;

  assign mode_bits = {pin_mode_control_b_q, pin_mode_control_a_q};

  for (genvar g = 0; g < PINS; g++) begin : g_pin
    wire [3:0] nib;
    assign nib             = mode_bits[g*PCS_NIB_W +: PCS_NIB_W];
    assign cfg[g].mode     = pcs_mode_e'(nib[PCS_MODE_LSB +: 2]);
    assign cfg[g].mask_sel = nib[PCS_MASK_LSB +: 2];
    assign cfg[g].invert   = strobe_invert_q[g];
    assign cfg[g].cmp      = {strobe_address_high_byte_q[g],
                              strobe_address_low_byte_q[g]};
    assign is_gpio[g]      = (cfg[g].mode == PCS_MODE_GPIO);

    pcs_strobe u_strobe (
      .cfg_i   (cfg[g]),
      .xbus_i  (xbus_i),
      .level_o (strobe_level[g])
    );
  end

  // ---------------------------------------------------------------
  // Port data write
  // ---------------------------------------------------------------
  // Only I/O pins take the new bit; strobe pins keep their old latch bit
  // so that a later return to mode 0 restores what software left there.
  assign port_four_data_d = (wr_lo && hit_data) ?
      ((wbyte[PINS-1:0] & is_gpio) | (port_four_data_q & ~is_gpio)) :
      port_four_data_q;

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_four_data_q     <= PCS_RST_DATA;
      pin_mode_control_a_q <= PCS_RST_MODE;
      pin_mode_control_b_q <= PCS_RST_MODE;
      strobe_invert_q      <= PCS_RST_INVERT;
    end else begin
      port_four_data_q <= port_four_data_d;
      if (wr_lo && hit_mode_a) begin
        pin_mode_control_a_q <= wbyte;
      end
      if (wr_lo && hit_mode_b) begin
        pin_mode_control_b_q <= wbyte;
      end
      if (wr_lo && hit_inv) begin
        strobe_invert_q <= wbyte[PINS-1:0];
      end
    end
  end

  // Comparator bytes live in small arrays, one entry per pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < PINS; i++) begin
        strobe_address_high_byte_q[i] <= PCS_RST_ADR;
        strobe_address_low_byte_q[i]  <= PCS_RST_ADR;
      end
    end else begin
      if (wr_lo && hit_hi) begin
        strobe_address_high_byte_q[idx_hi] <= wbyte;
      end
      if (wr_lo && hit_lo) begin
        strobe_address_low_byte_q[idx_lo] <= wbyte;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read data and acknowledge
  // ---------------------------------------------------------------
  // Every address is answered with a one-cycle acknowledge; unmapped
  // addresses read zero and drop writes, so software never hangs.
  wire [7:0] rbyte;

  assign rbyte = hit_data   ? {{(8-PINS){1'b0}}, port_four_data_q} :
                 hit_mode_a ? pin_mode_control_a_q :
                 hit_mode_b ? pin_mode_control_b_q :
                 hit_pins   ? {{(8-PINS){1'b0}}, pin_level_q} :
                 hit_inv    ? {{(8-PINS){1'b0}}, strobe_invert_q} :
                 hit_hi     ? strobe_address_high_byte_q[idx_hi] :
                 hit_lo     ? strobe_address_low_byte_q[idx_lo] :
                 8'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= bus_req;
      rdata_q <= bus_req ? {24'h00_0000, rbyte} : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  // An I/O pin is quasi-bidirectional: a 0 is driven hard, a 1 is left to
  // the pull-up so an outside party may pull it low and be read back.
  // Strobe pins drive both levels; the register adds one cycle of delay
  // behind the bus pulse, which the core's pulse timing must allow for.
  logic [PINS-1:0] pin_q;
  logic [PINS-1:0] pin_oe_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q    <= {PINS{1'b1}};
      pin_oe_q <= {PINS{1'b0}};
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (is_gpio[i]) begin
          pin_q[i]    <= 1'b0;
          pin_oe_q[i] <= !port_four_data_q[i];
        end else begin
          pin_q[i]    <= strobe_level[i];
          pin_oe_q[i] <= 1'b1;
        end
      end
    end
  end

  assign pin_o    = pin_q;
  assign pin_oe_o = pin_oe_q;

  // ---------------------------------------------------------------
  // External interrupt feed
  // ---------------------------------------------------------------
  // Pin 3 feeds interrupt two and pin 2 feeds interrupt three, only in
  // mode 0 with the matching enable; otherwise the line idles high.
  logic int_two_q;
  logic int_three_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_two_q   <= 1'b1;
      int_three_q <= 1'b1;
    end else begin
      int_two_q   <= (is_gpio[3] && int_two_en_i)   ? pin_level_q[3] : 1'b1;
      int_three_q <= (is_gpio[2] && int_three_en_i) ? pin_level_q[2] : 1'b1;
    end
  end

  assign external_interrupt_two_o   = int_two_q;
  assign external_interrupt_three_o = int_three_q;

endmodule
`default_nettype wire

// [pcs_pkg.sv]
/*
  Shared constants and types for the four-pin chip-select strobe port.
  Assumes a 32-bit classic Wishbone slave with byte addresses and 8-bit
  registers in the low byte lane.
*/
package pcs_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] PCS_OFF_DATA    = 8'hE8; // Port data latch.
  localparam logic [7:0] PCS_OFF_MODE_A  = 8'h00; // Mode/mask, pins 0 and 1.
  localparam logic [7:0] PCS_OFF_MODE_B  = 8'h04; // Mode/mask, pins 2 and 3.
  localparam logic [7:0] PCS_OFF_PINS    = 8'h08; // Filtered pin levels.
  localparam logic [7:0] PCS_OFF_INVERT  = 8'h0C; // Per-pin strobe invert.
  localparam logic [7:0] PCS_OFF_ADR_HI  = 8'h20; // High bytes, step 4.
  localparam logic [7:0] PCS_OFF_ADR_LO  = 8'h30; // Low bytes, step 4.
  localparam logic [7:0] PCS_OFF_STRIDE  = 8'h04; // Distance between pins.

  // ---------------------------------------------------------------
  // Field layout inside a mode control byte
  // ---------------------------------------------------------------
  localparam int PCS_NIB_W      = 4; // Bits per pin in a mode register.
  localparam int PCS_MASK_LSB   = 0; // Mask select at bits 1..0.
  localparam int PCS_MODE_LSB   = 2; // Mode at bits 3..2.

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] PCS_RST_DATA   = 4'hF; // Pins released high.
  localparam logic [7:0] PCS_RST_MODE   = 8'h00; // All pins plain I/O.
  localparam logic [3:0] PCS_RST_INVERT = 4'h0; // Active-low strobes.
  localparam logic [7:0] PCS_RST_ADR    = 8'h00;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PCS_MODE_GPIO,
    PCS_MODE_READ,
    PCS_MODE_WRITE,
    PCS_MODE_RDWR
  } pcs_mode_e;

  // Configuration of one pin, as seen by the strobe generator.
  typedef struct packed {
    pcs_mode_e   mode;
    logic [1:0]  mask_sel;
    logic        invert;
    logic [15:0] cmp;
  } pcs_pin_cfg_s;

  // External bus cycle as driven by the core, same clock domain.
  typedef struct packed {
    logic [15:0] addr;
    logic        rd_n;
    logic        wr_n;
  } pcs_xbus_s;

endpackage

// [pcs_strobe.sv]
/*
  One pin's chip-select strobe decoder, purely combinational.
  Assumes the external bus fields are stable within a core clock and are
  registered by the caller before reaching a pin.
*/
`timescale 1ns/100ps
`default_nettype none
module pcs_strobe
  import pcs_pkg::*;
(
  input  wire pcs_pkg::pcs_pin_cfg_s cfg_i,    // Pin configuration.
  input  wire pcs_pkg::pcs_xbus_s    xbus_i,   // External bus cycle.
  output logic                       level_o   // Pin level for the strobe.
);

  // ---------------------------------------------------------------
  // Address match under mask
  // ---------------------------------------------------------------
  // Mask select n ignores the lowest n address lines, so one strobe
  // covers a block of 1, 2, 4 or 8 consecutive addresses.
  wire [15:0] care_mask;
  wire        addr_hit;
  wire        rd_act;
  wire        wr_act;
  wire        strobe_on;

  assign care_mask = 16'hFFFF << cfg_i.mask_sel;
  assign addr_hit  = ((xbus_i.addr ^ cfg_i.cmp) & care_mask) == 16'h0000;

  // ---------------------------------------------------------------
  // Pulse qualification by mode
  // ---------------------------------------------------------------
  assign rd_act = !xbus_i.rd_n;
  assign wr_act = !xbus_i.wr_n;

  // The strobe is only ever true inside a qualifying pulse with a hit.
  assign strobe_on = addr_hit && (
      (cfg_i.mode == PCS_MODE_READ  && rd_act) ||
      (cfg_i.mode == PCS_MODE_WRITE && wr_act) ||
      (cfg_i.mode == PCS_MODE_RDWR  && (rd_act || wr_act)));

  // Default polarity is active low; the invert bit makes it active high.
  assign level_o = cfg_i.invert ? strobe_on : !strobe_on;

endmodule
`default_nettype wire

// [pcs_periph.sv]
/* Pad and peripheral model for the strobe port.
   Assumes pull-ups on all four pads and an external source that may sink. */
`timescale 1ns/100ps
`default_nettype none
module pcs_periph (
  input  wire logic [3:0] drv_i,     // Device drive values.
  input  wire logic [3:0] oe_i,      // Device enables.
  input  wire logic [3:0] pull_lo_i, // External sink per pad.
  output logic      [3:0] wire_o     // Resolved pad levels.
);
  // ---------------------------------------------------------------
  // Pad resolution
  // ---------------------------------------------------------------
  // A released pad floats to its pull-up unless something sinks it.
  assign wire_o = (oe_i & drv_i) | (~oe_i & ~pull_lo_i);
endmodule
`default_nettype wire

// [pcs_port_chk.sv]
/* Assertion checker for pcs_port.
   Assumes it sees only the ports and shadows the registers itself. */
`timescale 1ns/100ps
`default_nettype none
module pcs_port_chk
  import pcs_pkg::*;
#(
  parameter int PINS = 4 // Pin count.
)(
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic [7:0]       wb_adr_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic             wb_we_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire pcs_pkg::pcs_xbus_s xbus_i,
  input wire logic             int_two_en_i,
  input wire logic             int_three_en_i,
  input wire logic [PINS-1:0]  pin_i,
  input wire logic [PINS-1:0]  pin_o,
  input wire logic [PINS-1:0]  pin_oe_o,
  input wire logic             external_interrupt_two_o,
  input wire logic             external_interrupt_three_o
);
  // ---------------------------------------------------------------
  // Register shadow
  // ---------------------------------------------------------------
  logic [7:0]      ma_q, mb_q;   // Mode bytes.
  logic [3:0]      inv_q, dat_q; // Invert bits and data latch.
  logic [3:0][7:0] hi_q, lo_q;   // Comparator bytes.
  logic [3:0]      exp_d, exp_q; // Expected pad levels.
  logic [3:0]      gp_d, gp_q;   // Pins in plain I/O mode.
  wire  [15:0]     mode_w = {mb_q, ma_q};
  wire             take_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire             wr_w   = take_w & wb_we_i & wb_sel_i[0];
  wire  [7:0]      wd_w   = wb_dat_i[7:0];
  wire  [3:0]      pad_w  = pin_o | ~pin_oe_o; // Pull-up when released.

  // Writes land at the taking edge, as the design stores them.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ma_q  <= 8'h00;
      mb_q  <= 8'h00;
      inv_q <= 4'h0;
      dat_q <= 4'hF;
      hi_q  <= '0;
      lo_q  <= '0;
    end else if (wr_w) begin
      if (wb_adr_i == PCS_OFF_MODE_A) ma_q <= wd_w;
      if (wb_adr_i == PCS_OFF_MODE_B) mb_q <= wd_w;
      if (wb_adr_i == PCS_OFF_INVERT) inv_q <= wd_w[3:0];
      if (wb_adr_i == PCS_OFF_DATA) dat_q <= (dat_q & ~gp_d) | (wd_w[3:0] & gp_d);
      for (int n = 0; n < 4; n++) begin
        if (wb_adr_i == PCS_OFF_ADR_HI + 8'(n) * PCS_OFF_STRIDE) hi_q[n] <= wd_w;
        if (wb_adr_i == PCS_OFF_ADR_LO + 8'(n) * PCS_OFF_STRIDE) lo_q[n] <= wd_w;
      end
    end
  end

  // Expected level: masked compare gated by the selected pulse.
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      logic [3:0] nb;
      logic       hit;
      nb       = mode_w[4*n +: 4];
      hit      = (((xbus_i.addr ^ {hi_q[n], lo_q[n]}) >> nb[1:0]) == 16'h0000)
                 && ((nb[2] && !xbus_i.rd_n) || (nb[3] && !xbus_i.wr_n));
      gp_d[n]  = nb[3:2] == 2'h0;
      exp_d[n] = gp_d[n] ? dat_q[n] : (hit ? inv_q[n] : !inv_q[n]);
    end
  end

  // The pads follow one edge later.
  always_ff @(posedge clk_i) begin
    exp_q <= rst_i ? 4'hF : exp_d;
    gp_q  <= rst_i ? 4'hF : gp_d;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wb_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence data_read;
    wb_take ##0 (!wb_we_i && wb_adr_i == PCS_OFF_DATA);
  endsequence
  // A long stable level must reach the interrupt line unchanged.
  property irq_follow(logic en, logic lvl, logic gp, logic irq);
    (en && gp && $stable(lvl)) [*6] |-> irq == lvl;
  endproperty

  chk_ack_latency: assert property (wb_take |=> wb_ack_o)
    else $error("ack not one cycle after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data not zero outside ack");
  chk_data_read: assert property (data_read |=> wb_dat_o == {28'h0000000, dat_q})
    else $error("data latch read mismatch");
  chk_io_level: assert property (((pad_w ^ exp_q) & gp_q) == 4'h0)
    else $error("io pin level mismatch");
  chk_strobe_level: assert property (((pad_w ^ exp_q) & ~gp_q) == 4'h0)
    else $error("strobe pin level mismatch");
  chk_irq_two: assert property (irq_follow(int_two_en_i, pin_i[3], gp_q[3], external_interrupt_two_o))
    else $error("interrupt two does not follow pin 3");
  chk_irq_three: assert property (irq_follow(int_three_en_i, pin_i[2], gp_q[2], external_interrupt_three_o))
    else $error("interrupt three does not follow pin 2");
endmodule
bind pcs_port pcs_port_chk #(.PINS(PINS)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
  .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .xbus_i(xbus_i), .int_two_en_i(int_two_en_i),
  .int_three_en_i(int_three_en_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
  .external_interrupt_two_o(external_interrupt_two_o),
  .external_interrupt_three_o(external_interrupt_three_o));
`default_nettype wire

// [pcs_port_tb.sv]
/* Self-checking bench for pcs_port.
   Assumes pcs_pkg, pcs_periph and the bound checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module pcs_port_tb;
  import pcs_pkg::*;
  logic        clk, rst, we, cyc, stb, ack, en2, en3, irq2, irq3;
  logic [7:0]  adr, q;
  logic [31:0] wdat, rdat;
  logic [3:0]  sel, pull_lo, pin_o, pin_oe, inv;
  pcs_xbus_s   xbus;
  wire  [3:0]  pads;
  int          errors, n_compared;
  logic [3:0]  nb [4];
  logic [15:0] cmp [4];

  pcs_port #(.PINS(4)) u_dut (
    .clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .xbus_i(xbus),
    .int_two_en_i(en2), .int_three_en_i(en3), .pin_i(pads), .pin_o(pin_o), .pin_oe_o(pin_oe),
    .external_interrupt_two_o(irq2), .external_interrupt_three_o(irq3));
  pcs_periph u_periph (.drv_i(pin_o), .oe_i(pin_oe), .pull_lo_i(pull_lo), .wire_o(pads));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  task automatic complete_run;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // One classic cycle; an idle cycle follows so strobe drops for a cycle.
  task automatic wbx(input logic [7:0] a, input logic w, input logic [7:0] d);
    int t;
    t = 0;
    adr <= a;
    we <= w;
    wdat <= {24'h000000, d};
    cyc <= 1'h1;
    stb <= 1'h1;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'h1 && t < 50);
    if (t >= 50) chk(8'h00, 8'h01, "ack timeout");
    q = rdat[7:0];
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wbx(a, 1'h1, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    wbx(a, 1'h0, 8'h00);
    chk(q, e, "register read");
  endtask

  function automatic logic lvl(input int n, input logic [15:0] a, input logic r, input logic w);
    logic h;
    h = (((a ^ cmp[n]) >> nb[n][1:0]) == 16'h0000) && ((nb[n][2] && r) || (nb[n][3] && w));
    return h ? inv[n] : !inv[n];
  endfunction

  // Pulse for two cycles, then check the strobe and its return to idle.
  task automatic xacc(input int n, input logic [15:0] a, input logic r, input logic w);
    xbus <= '{addr: a, rd_n: !r, wr_n: !w};
    @(posedge clk);
    @(posedge clk);
    chk({7'h00, pads[n]}, {7'h00, lvl(n, a, r, w)}, "strobe level");
    xbus <= '{addr: a, rd_n: 1'h1, wr_n: 1'h1};
    repeat (2) @(posedge clk);
    chk({7'h00, pads[n]}, {7'h00, !inv[n]}, "strobe idle");
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge clk);
    chk(8'h00, 8'h01, "watchdog expired");
    complete_run();
  end

  initial begin
    rst = 1'h1;
    {cyc, stb, we, adr, wdat, pull_lo} = '0;
    {sel, en2, en3} = 6'h3F;
    xbus = '{addr: 16'h0000, rd_n: 1'h1, wr_n: 1'h1};
    errors = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rdc(PCS_OFF_DATA, {4'h0, PCS_RST_DATA});
    rdc(PCS_OFF_MODE_A, PCS_RST_MODE);
    rdc(PCS_OFF_MODE_B, PCS_RST_MODE);
    rdc(8'h10, 8'h00);
    $display("test reset done");
    nb = '{4'hA, 4'h4, 4'hD, 4'h0};
    cmp = '{16'h1234, 16'h8001, 16'h00F0, 16'hFFFF};
    for (int n = 0; n < 4; n++) begin
      wr(PCS_OFF_ADR_HI + 8'(4 * n), cmp[n][15:8]);
      wr(PCS_OFF_ADR_LO + 8'(4 * n), cmp[n][7:0]);
      rdc(PCS_OFF_ADR_HI + 8'(4 * n), cmp[n][15:8]);
      rdc(PCS_OFF_ADR_LO + 8'(4 * n), cmp[n][7:0]);
    end
    sel <= 4'h0;
    wr(PCS_OFF_INVERT, 8'h0F);
    sel <= 4'hF;
    rdc(PCS_OFF_INVERT, 8'h00);
    inv = 4'h1;
    wr(PCS_OFF_INVERT, {4'h0, inv});
    rdc(PCS_OFF_INVERT, {4'h0, inv});
    $display("test registers done");
    wr(PCS_OFF_DATA, 8'h05);
    repeat (6) @(posedge clk);
    chk({4'h0, pads}, 8'h05, "io level");
    rdc(PCS_OFF_PINS, 8'h05);
    wr(PCS_OFF_DATA, 8'h0F);
    $display("test io done");
    wr(PCS_OFF_MODE_A, {nb[1], nb[0]});
    wr(PCS_OFF_MODE_B, {nb[3], nb[2]});
    rdc(PCS_OFF_MODE_A, {nb[1], nb[0]});
    for (int n = 0; n < 3; n++) begin
      for (int k = 0; k < 6; k++) begin
        xacc(n, cmp[n] - 16'h0001 + 16'(k), 1'h1, 1'h0);
        xacc(n, cmp[n] - 16'h0001 + 16'(k), 1'h0, 1'h1);
      end
    end
    $display("test strobes done");
    wr(PCS_OFF_DATA, 8'h00);
    repeat (2) @(posedge clk);
    chk({4'h0, pads}, 8'h06, "data write with strobes");
    rdc(PCS_OFF_DATA, 8'h07);
    wr(PCS_OFF_MODE_A, 8'h00);
    wr(PCS_OFF_MODE_B, 8'h00);
    repeat (2) @(posedge clk);
    chk({4'h0, pads}, 8'h07, "back to io");
    $display("test data write done");
    repeat (8) @(posedge clk);
    chk({6'h00, irq2, irq3}, 8'h01, "irq from pin 3");
    pull_lo <= 4'h4;
    repeat (8) @(posedge clk);
    chk({6'h00, irq2, irq3}, 8'h00, "irq from pin 2");
    en3 <= 1'h0;
    repeat (3) @(posedge clk);
    chk({6'h00, irq2, irq3}, 8'h01, "irq three disabled");
    en3 <= 1'h1;
    pull_lo <= 4'h0;
    wr(PCS_OFF_DATA, 8'h0F);
    repeat (8) @(posedge clk);
    chk({6'h00, irq2, irq3}, 8'h03, "irq idle");
    rdc(PCS_OFF_PINS, 8'h0F);
    $display("test interrupts done");
    complete_run();
  end
endmodule
`default_nettype wire
